// File: lvmon_defines.vh
`ifndef LVMON_DEFINES_VH
`define LVMON_DEFINES_VH
// ----------------------------------------
// Register offsets.
// ----------------------------------------
`define LVMON_UPPER_LO_ADDR 12'h247
`define LVMON_UPPER_HI_ADDR 12'h248
`define LVMON_LOWER_LO_ADDR 12'h249
`define LVMON_LOWER_HI_ADDR 12'h24A
`define LVMON_DWELL_LO_ADDR 12'h24B
`define LVMON_DWELL_HI_ADDR 12'h24C
`define LVMON_MON_CTRL_ADDR 12'h270
`define LVMON_PERIOD_B0_ADDR 12'h271
`define LVMON_PERIOD_B1_ADDR 12'h272
`define LVMON_PERIOD_B2_ADDR 12'h273
`define LVMON_HOLD_LO_ADDR 12'h274
`define LVMON_HOLD_HI_ADDR 12'h275
`define LVMON_SER_CTRL_ADDR 12'h279
`define LVMON_SER_EN_ADDR 12'h27A
`define LVMON_CB_SEL_A_ADDR 12'h559
`define LVMON_CB_SEL_B_ADDR 12'h55A
`define LVMON_OR_CLEAR_ADDR 12'h562
`define LVMON_OR_STATUS_ADDR 12'h563
`define LVMON_CB_SRC_ADDR 12'h58F
// ----------------------------------------
// Field positions.
// ----------------------------------------
`define LVMON_PEAK_EN_BIT 1
`define LVMON_SER_EN_BIT 1
`define LVMON_CB_FD_BIT 0
`define LVMON_CB_OR_BIT 1
// ----------------------------------------
// Reset values and timing counts.
// ----------------------------------------
`define LVMON_REG_RESET 8'h00
`define LVMON_DWELL_RESET 16'h0001
`define LVMON_UPPER_LATENCY 28
`define LVMON_FRAME_BITS 25
`define LVMON_SUBFRAME_BITS 5
`endif

// File: lvmon_top.v
// What this block does
// RQ1 - Overrange indicator follows sample latency exactly
// RQ2 - Overrange can ride as a control bit
// RQ3 - Sticky overrange bit per virtual converter
// RQ4 - Clear bit toggled one-then-zero clears status
// RQ5 - Alert sets when magnitude exceeds upper threshold
// RQ6 - Alert clears after dwell below lower threshold
// RQ7 - Upper threshold alert has latency 28
// RQ8 - Lower threshold is 13 bits, full latency
// RQ9 - Dwell accepts 1 to 65535 cycles
// RQ10 - Alert bit in control bits when enabled
// RQ11 - Independent alert logic and pin per channel
// RQ12 - Peak tracks 13-bit magnitude, 24-bit period
// RQ13 - Software programs even period before enabling
// RQ14 - Peak detection enabled by monitor control bit 1
// RQ15 - Enable loads period into decrementing timer
// RQ16 - Peak storage starts at input, keeps larger
// RQ17 - At count 1 copy peak, reload, restart
// RQ18 - Serial stats enabled by two control registers
// RQ19 - Control bits filled from most significant down
// RQ20 - Serial stats selected by source select register
// RQ21 - 25-bit frame, MSB first, five subframes
// RQ22 - Receiver reassembles frames from control bits
// RQ23 - Subframe is start bit then four data bits
`include "lvmon_defines.vh"
module lvmon_top #(
  parameter VCONV = 8,
  parameter MAG_W = 13,
  parameter LAT = `LVMON_UPPER_LATENCY
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Register port.
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Converter samples per channel and decimated sample strobe.
  input wire [13:0] sample_a,
  input wire [13:0] sample_b,
  input wire over_a,
  input wire over_b,
  input wire [VCONV-1:0] vconv_over,
  input wire dec_stb,
  // Delayed sample stream with control bits, through a two-entry buffer.
  output wire out_valid,
  input wire out_ready,
  output wire [13:0] out_data_a,
  output wire [2:0] out_ctrl_a,
  output wire [13:0] out_data_b,
  output wire [2:0] out_ctrl_b,
  output wire in_ready,
  // Alert pins.
  output reg level_alert_pin_a,
  output reg level_alert_pin_b
);
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  // Magnitude of a signed sample, saturated to 13 bits.
  function [12:0] mag;
    input [13:0] s;
    reg [13:0] t;
    begin
      t = s[13] ? (~s + 14'h0001) : s;
      mag = (t[13]) ? 13'h1FFF : t[12:0];
    end
  endfunction
  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  reg [15:0] upper_reg;
  reg [15:0] lower_reg;
  reg [15:0] dwell_reg;
  reg [7:0] mon_ctrl_reg;
  reg [23:0] period_reg;
  reg [7:0] ser_ctrl_reg;
  reg [7:0] ser_en_reg;
  reg [7:0] cb_sel_a_reg;
  reg [7:0] cb_sel_b_reg;
  reg [7:0] or_clear_reg;
  reg [VCONV-1:0] or_status_reg;
  reg [7:0] cb_src_reg;
  reg [12:0] hold_reg;
  // Register writes.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      upper_reg <= 16'h0000;
      lower_reg <= 16'h0000;
      dwell_reg <= `LVMON_DWELL_RESET;
      mon_ctrl_reg <= `LVMON_REG_RESET;
      period_reg <= 24'h000000;
      ser_ctrl_reg <= `LVMON_REG_RESET;
      ser_en_reg <= `LVMON_REG_RESET;
      cb_sel_a_reg <= `LVMON_REG_RESET;
      cb_sel_b_reg <= `LVMON_REG_RESET;
      or_clear_reg <= `LVMON_REG_RESET;
      cb_src_reg <= `LVMON_REG_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `LVMON_UPPER_LO_ADDR)
        upper_reg[7:0] <= reg_wdata;
      else if (reg_addr == `LVMON_UPPER_HI_ADDR)
        upper_reg[15:8] <= reg_wdata;
      else if (reg_addr == `LVMON_LOWER_LO_ADDR)
        lower_reg[7:0] <= reg_wdata;
      else if (reg_addr == `LVMON_LOWER_HI_ADDR)
        lower_reg[15:8] <= reg_wdata;
      else if (reg_addr == `LVMON_DWELL_LO_ADDR)
        dwell_reg[7:0] <= reg_wdata; // RQ9
      else if (reg_addr == `LVMON_DWELL_HI_ADDR)
        dwell_reg[15:8] <= reg_wdata; // RQ9
      else if (reg_addr == `LVMON_MON_CTRL_ADDR)
        mon_ctrl_reg <= reg_wdata;
      else if (reg_addr == `LVMON_PERIOD_B0_ADDR)
        period_reg[7:0] <= reg_wdata;
      else if (reg_addr == `LVMON_PERIOD_B1_ADDR)
        period_reg[15:8] <= reg_wdata;
      else if (reg_addr == `LVMON_PERIOD_B2_ADDR)
        period_reg[23:16] <= reg_wdata;
      else if (reg_addr == `LVMON_SER_CTRL_ADDR)
        ser_ctrl_reg <= reg_wdata;
      else if (reg_addr == `LVMON_SER_EN_ADDR)
        ser_en_reg <= reg_wdata;
      else if (reg_addr == `LVMON_CB_SEL_A_ADDR)
        cb_sel_a_reg <= reg_wdata;
      else if (reg_addr == `LVMON_CB_SEL_B_ADDR)
        cb_sel_b_reg <= reg_wdata;
      else if (reg_addr == `LVMON_OR_CLEAR_ADDR)
        or_clear_reg <= reg_wdata;
      else if (reg_addr == `LVMON_CB_SRC_ADDR)
        cb_src_reg <= reg_wdata;
    end
  end
  // Register reads; unmapped offsets read zero.
  always @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `LVMON_UPPER_LO_ADDR)
        reg_rdata <= upper_reg[7:0];
      else if (reg_addr == `LVMON_UPPER_HI_ADDR)
        reg_rdata <= upper_reg[15:8];
      else if (reg_addr == `LVMON_LOWER_LO_ADDR)
        reg_rdata <= lower_reg[7:0];
      else if (reg_addr == `LVMON_LOWER_HI_ADDR)
        reg_rdata <= lower_reg[15:8];
      else if (reg_addr == `LVMON_DWELL_LO_ADDR)
        reg_rdata <= dwell_reg[7:0];
      else if (reg_addr == `LVMON_DWELL_HI_ADDR)
        reg_rdata <= dwell_reg[15:8];
      else if (reg_addr == `LVMON_MON_CTRL_ADDR)
        reg_rdata <= mon_ctrl_reg;
      else if (reg_addr == `LVMON_PERIOD_B0_ADDR)
        reg_rdata <= period_reg[7:0];
      else if (reg_addr == `LVMON_PERIOD_B1_ADDR)
        reg_rdata <= period_reg[15:8];
      else if (reg_addr == `LVMON_PERIOD_B2_ADDR)
        reg_rdata <= period_reg[23:16];
      else if (reg_addr == `LVMON_HOLD_LO_ADDR)
        reg_rdata <= hold_reg[7:0];
      else if (reg_addr == `LVMON_HOLD_HI_ADDR)
        reg_rdata <= {3'h0, hold_reg[12:8]};
      else if (reg_addr == `LVMON_SER_CTRL_ADDR)
        reg_rdata <= ser_ctrl_reg;
      else if (reg_addr == `LVMON_SER_EN_ADDR)
        reg_rdata <= ser_en_reg;
      else if (reg_addr == `LVMON_CB_SEL_A_ADDR)
        reg_rdata <= cb_sel_a_reg;
      else if (reg_addr == `LVMON_CB_SEL_B_ADDR)
        reg_rdata <= cb_sel_b_reg;
      else if (reg_addr == `LVMON_OR_CLEAR_ADDR)
        reg_rdata <= or_clear_reg;
      else if (reg_addr == `LVMON_OR_STATUS_ADDR)
        reg_rdata <= or_status_reg; // RQ3
      else if (reg_addr == `LVMON_CB_SRC_ADDR)
        reg_rdata <= cb_src_reg;
      else
        reg_rdata <= 8'h00;
    end
  end
  // ----------------------------------------
  // Sticky overrange status.
  // ----------------------------------------
  // A clear bit that has gone from one back to zero clears status; a new
  // overrange in that same cycle wins.
  wire clr_fall = reg_wr && (reg_addr == `LVMON_OR_CLEAR_ADDR);
  wire [VCONV-1:0] clr_mask = clr_fall ? (or_clear_reg[VCONV-1:0] & ~reg_wdata[VCONV-1:0])
    : {VCONV{1'b0}};
  always @(posedge clk)
  begin
    if (sys_rst)
      or_status_reg <= {VCONV{1'b0}};
    else
      or_status_reg <= (or_status_reg & ~clr_mask) | vconv_over; // RQ3 RQ4
  end
  // ----------------------------------------
  // Sample delay line matching the alert latency.
  // ----------------------------------------
  reg [29:0] dly [0:LAT-1];
  integer i;
  // Samples and overrange travel together so both see the same latency.
  always @(posedge clk)
  begin
    dly[0] <= {over_b, sample_b, over_a, sample_a}; // RQ1
    for (i = 1; i < LAT; i = i + 1)
      dly[i] <= dly[i-1];
  end
  // ----------------------------------------
  // Alert comparators, one per channel.
  // ----------------------------------------
  reg [15:0] dwell_cnt_a;
  reg [15:0] dwell_cnt_b;
  wire [12:0] mag_a = mag(dly[LAT-1][13:0]);
  wire [12:0] mag_b = mag(dly[LAT-1][28:15]);
  // Set on upper crossing; clear once below lower for more than dwell cycles.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      level_alert_pin_a <= 1'b0;
      level_alert_pin_b <= 1'b0;
      dwell_cnt_a <= 16'h0000;
      dwell_cnt_b <= 16'h0000;
    end
    else
    begin
      if ({3'h0, mag_a} > upper_reg)
      begin
        level_alert_pin_a <= 1'b1; // RQ5 RQ7 RQ11
        dwell_cnt_a <= 16'h0000;
      end
      else if ({3'h0, mag_a} < {3'h0, lower_reg[12:0]})
      begin
        if (dwell_cnt_a >= dwell_reg)
          level_alert_pin_a <= 1'b0; // RQ6 RQ8
        else
          dwell_cnt_a <= dwell_cnt_a + 16'h0001;
      end
      else
        dwell_cnt_a <= 16'h0000;
      if ({3'h0, mag_b} > upper_reg)
      begin
        level_alert_pin_b <= 1'b1; // RQ5 RQ7 RQ11
        dwell_cnt_b <= 16'h0000;
      end
      else if ({3'h0, mag_b} < {3'h0, lower_reg[12:0]})
      begin
        if (dwell_cnt_b >= dwell_reg)
          level_alert_pin_b <= 1'b0; // RQ6 RQ8
        else
          dwell_cnt_b <= dwell_cnt_b + 16'h0001;
      end
      else
        dwell_cnt_b <= 16'h0000;
    end
  end
  // ----------------------------------------
  // Peak monitor.
  // ----------------------------------------
  reg [23:0] timer_reg;
  reg [12:0] peak_reg;
  reg run_reg;
  reg frame_stb;
  wire [12:0] mon_mag = (mag(sample_a) > mag(sample_b)) ? mag(sample_a) : mag(sample_b);
  wire pk_en = mon_ctrl_reg[`LVMON_PEAK_EN_BIT]; // RQ14
  // Timer counts decimated samples; at one it hands the peak over.
  always @(posedge clk)
  begin
    frame_stb <= 1'b0;
    if (sys_rst || !pk_en)
    begin
      run_reg <= 1'b0;
      timer_reg <= 24'h000000;
      peak_reg <= 13'h0000;
      if (sys_rst)
        hold_reg <= 13'h0000;
    end
    else if (!run_reg)
    begin
      run_reg <= 1'b1;
      timer_reg <= period_reg; // RQ15
      peak_reg <= mon_mag; // RQ16
    end
    else if (dec_stb)
    begin
      if (timer_reg <= 24'h000001)
      begin
        hold_reg <= (mon_mag > peak_reg) ? mon_mag : peak_reg; // RQ12 RQ17
        frame_stb <= 1'b1;
        timer_reg <= period_reg; // RQ17
        peak_reg <= 13'h0000; // RQ17
      end
      else
      begin
        timer_reg <= timer_reg - 24'h000001; // RQ15
        peak_reg <= (mon_mag > peak_reg) ? mon_mag : peak_reg; // RQ16
      end
    end
  end
  // ----------------------------------------
  // Embedded stats serializer.
  // ----------------------------------------
  reg [24:0] sh_reg;
  reg [4:0] sh_cnt;
  wire ser_on = (ser_ctrl_reg[1:0] == 2'b11) && ser_en_reg[`LVMON_SER_EN_BIT]; // RQ18
  wire sel_ser = ser_on && (cb_src_reg != 8'h00); // RQ20
  // Each subframe is a start bit of one and four data bits, MSB first; the peak fills the last 13 data bits.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sh_reg <= 25'h0000000;
      sh_cnt <= 5'h00;
    end
    else if (frame_stb && ser_on)
    begin
      sh_reg <= {1'b1, 4'h0, 1'b1, 3'h0, hold_reg[12], 1'b1, hold_reg[11:8],
        1'b1, hold_reg[7:4], 1'b1, hold_reg[3:0]}; // RQ21 RQ23
      sh_cnt <= 5'd25;
    end
    else if (dec_stb && sh_cnt != 5'h00)
    begin
      sh_reg <= {sh_reg[23:0], 1'b0}; // RQ21
      sh_cnt <= sh_cnt - 5'h01;
    end
  end
  // Control bits fill from the most significant position.
  wire ser_bit = (sh_cnt != 5'h00) && sh_reg[24];
  wire fd_on = cb_sel_a_reg[`LVMON_CB_FD_BIT] && cb_sel_b_reg[`LVMON_CB_FD_BIT]; // RQ10
  wire or_on = cb_sel_a_reg[`LVMON_CB_OR_BIT] && cb_sel_b_reg[`LVMON_CB_OR_BIT]; // RQ2
  wire [2:0] cb_a = sel_ser ? {ser_bit, 2'b00} : {fd_on & level_alert_pin_a,
    or_on & dly[LAT-1][14], 1'b0}; // RQ19 RQ2
  wire [2:0] cb_b = sel_ser ? {ser_bit, 2'b00} : {fd_on & level_alert_pin_b,
    or_on & dly[LAT-1][29], 1'b0}; // RQ19
  // ----------------------------------------
  // Two-entry output buffer.
  // ----------------------------------------
  reg [33:0] buf_mem [0:1];
  reg wp, rp;
  reg [1:0] cnt;
  wire push = (cnt != 2'd2);
  wire pop = out_valid && out_ready;
  assign in_ready = push;
  assign out_valid = (cnt != 2'd0);
  assign {out_ctrl_b, out_data_b, out_ctrl_a, out_data_a} = buf_mem[rp];
  // Each clock offers one word; a full buffer drops it and shows in_ready low.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wp] <= {cb_b, dly[LAT-1][28:15], cb_a, dly[LAT-1][13:0]};
        wp <= ~wp;
      end
      if (pop)
        rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // lvmon_top

// File: lvmon_top_asserts.sv
// ----
// Checker for the level monitor ports.
// ----
module lvmon_top_asserts #(
  parameter int LAT = 28
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Register port.
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Samples and status inputs.
  input wire [13:0] sample_a,
  input wire [13:0] sample_b,
  input wire [7:0] vconv_over,
  // Stream and alert pins.
  input wire out_valid,
  input wire out_ready,
  input wire [13:0] out_data_a,
  input wire [2:0] out_ctrl_a,
  input wire level_alert_pin_a,
  input wire level_alert_pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT_LO = LAT;
  localparam int LAT_HI = LAT + 2;
  logic [15:0] upper_reg;
  wire [15:0] mag_a = {2'b00, sample_a[13] ? 14'h0000 - sample_a : sample_a};
  wire [15:0] mag_b = {2'b00, sample_b[13] ? 14'h0000 - sample_b : sample_b};
  // Shadow of the upper threshold, so an alert can be tied to its sample.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upper_reg <= 16'h0000;
    else if (reg_wr && reg_addr == 12'h247)
      upper_reg[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == 12'h248)
      upper_reg[15:8] <= reg_wdata;
  end
  a_alert_a_rise: assert property (@(posedge clk) disable iff (sys_rst)
    mag_a > upper_reg |-> ##[LAT_LO:LAT_HI] level_alert_pin_a)
    else $error("Pin A missed a large sample.");
  a_alert_b_rise: assert property (@(posedge clk) disable iff (sys_rst)
    mag_b > upper_reg |-> ##[LAT_LO:LAT_HI] level_alert_pin_b)
    else $error("Pin B missed a large sample.");
  a_alert_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(level_alert_pin_a) |=> level_alert_pin_a)
    else $error("Pin A dropped without dwell.");
  a_sticky_set: assert property (@(posedge clk) disable iff (sys_rst)
    (vconv_over[0] && !reg_wr) ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == 12'h563)
    |=> reg_rdata[0])
    else $error("Sticky overrange bit not set.");
  a_sticky_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 12'h562 && reg_wdata == 8'hFF)
    ##1 (reg_wr && reg_addr == 12'h562 && reg_wdata == 8'h00 && vconv_over == 8'h00)
    ##1 (reg_rd && reg_addr == 12'h563) |=> reg_rdata == 8'h00)
    else $error("Sticky bits not cleared.");
  a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read.");
  a_stall_hold: assert property (@(posedge clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data_a) && $stable(out_ctrl_a))
    else $error("Stalled word changed.");
  a_reset_quiet: assert property (@(posedge clk)
    sys_rst |=> !out_valid && !level_alert_pin_a && reg_rdata == 8'h00)
    else $error("Outputs active after reset.");
endmodule // lvmon_top_asserts

bind lvmon_top lvmon_top_asserts #(.LAT(LAT)) u_asserts (.clk(clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b), .vconv_over(vconv_over),
  .out_valid(out_valid), .out_ready(out_ready), .out_data_a(out_data_a),
  .out_ctrl_a(out_ctrl_a), .level_alert_pin_a(level_alert_pin_a),
  .level_alert_pin_b(level_alert_pin_b));

// File: lvmon_link_rx.sv
// ----
// Link receiver model.
// ----
module lvmon_link_rx (
  // Clock, reset and pacing.
  input wire clk,
  input wire sys_rst,
  input wire slow,
  input wire [13:0] probe,
  // Stream from the block.
  input wire out_valid,
  output logic out_ready = 1'b1,
  input wire [13:0] out_data_a,
  input wire [2:0] out_ctrl_a,
  // Recovered results.
  output logic [2:0] probe_ctrl,
  output logic [12:0] frame_peak,
  output logic [7:0] frame_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] sr_reg;
  logic [4:0] bit_reg;
  logic [2:0] pace_reg;
  // Takes words, stalls on a fixed pattern when slow, and rebuilds frames.
  always @(posedge clk)
  begin
    pace_reg <= pace_reg + 3'h1;
    out_ready <= !slow || pace_reg == 3'h0;
    if (sys_rst)
    begin
      bit_reg <= 5'h00;
      frame_cnt <= 8'h00;
      probe_ctrl <= 3'h0;
      pace_reg <= 3'h0;
    end
    else if (out_valid && out_ready)
    begin
      if (out_data_a == probe)
        probe_ctrl <= out_ctrl_a;
      if (bit_reg != 5'h00 || out_ctrl_a[2])
      begin
        sr_reg <= {sr_reg[22:0], out_ctrl_a[2]};
        bit_reg <= (bit_reg == 5'h18) ? 5'h00 : bit_reg + 5'h01;
      end
      // Start bits validate the frame before the peak is taken.
      if (bit_reg == 5'h18
        && {sr_reg[23], sr_reg[18], sr_reg[13], sr_reg[8], sr_reg[3]} == 5'h1F)
      begin
        frame_peak <= {sr_reg[14], sr_reg[12:9], sr_reg[7:4], sr_reg[2:0], out_ctrl_a[2]};
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end
endmodule // lvmon_link_rx

// File: lvmon_top_bench.sv
// ----
// Level monitor testbench.
// ----
module lvmon_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, reg_wr, reg_rd, over_a, ov, slow, out_ready, in_ready, out_valid;
  logic alert_a, alert_b, flip, saw_full, rd_q;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vconv_over, frame_cnt, fc_q, rq[$];
  logic [13:0] amp_a, amp_b, sample_a, sample_b, out_data_a, out_data_b, probe;
  logic [2:0] out_ctrl_a, out_ctrl_b, probe_ctrl;
  logic [16:0] pb;
  logic [12:0] frame_peak;
  logic [15:0] fq[$];
  logic [31:0] v, r;
  logic [19:0] cfg[16] = '{20'h247FF, 20'h2480F, 20'h2491D, 20'h24A0A, 20'h24B04, 20'h24C00,
    20'h55903, 20'h55A03, 20'h27128, 20'h27200, 20'h27300, 20'h27903, 20'h27A02, 20'h58F01,
    20'h55900, 20'h55A00};
  int errors, samples_checked, seed, k;
  lvmon_top dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_a(sample_a),
    .sample_b(sample_b), .over_a(over_a), .over_b(over_a), .vconv_over(vconv_over),
    .dec_stb(1'b1), .out_valid(out_valid), .out_ready(out_ready), .out_data_a(out_data_a),
    .out_ctrl_a(out_ctrl_a), .out_data_b(out_data_b), .out_ctrl_b(out_ctrl_b),
    .in_ready(in_ready),
    .level_alert_pin_a(alert_a), .level_alert_pin_b(alert_b));
  lvmon_link_rx rx (.clk(clk), .sys_rst(sys_rst), .slow(slow), .probe(probe),
    .out_valid(out_valid), .out_ready(out_ready), .out_data_a(out_data_a),
    .out_ctrl_a(out_ctrl_a), .probe_ctrl(probe_ctrl), .frame_peak(frame_peak),
    .frame_cnt(frame_cnt));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One register cycle; a read notes the value it expects.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      rq.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (c) @(posedge clk);
  endtask
  task automatic frames(input int c);
    logic [7:0] goal;
    int t;
    goal = frame_cnt + c[7:0];
    t = 0;
    while (frame_cnt !== goal && t < 200 * c)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 200 * c)
    begin
      errors++;
      results();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Drives both channels, flipping signs at random when asked.
  always @(posedge clk)
  begin
    r = $random(seed);
    sample_a <= (flip && r[0]) ? 14'h0000 - amp_a : amp_a;
    sample_b <= (flip && r[1]) ? 14'h0000 - amp_b : amp_b;
    over_a <= ov;
    rd_q <= reg_rd;
  end
  // Compares each read answer and each recovered frame with the oldest note, while one waits.
  always @(negedge clk)
  begin
    if (rd_q && rq.size() > 0)
      check({8'h00, reg_rdata}, {8'h00, rq.pop_front()}, "read data");
    if (frame_cnt != fc_q && fq.size() > 0)
      check({3'h0, frame_peak}, fq.pop_front(), "frame peak");
    fc_q = frame_cnt;
    if (!in_ready)
      saw_full = 1'b1;
    // Channel B word that travels beside the probe word on channel A.
    if (out_valid && out_ready && out_data_a === probe)
      pb = {out_ctrl_b, out_data_b};
  end
  initial
  begin
    seed = 32'h598E;
    {sys_rst, reg_wr, reg_rd, over_a, ov, slow, flip, saw_full} = 8'h80;
    {reg_addr, reg_wdata, vconv_over, amp_a, amp_b, sample_a, sample_b} = 0;
    probe = 14'h0123;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 5; k++)
    begin
      v = $random(seed);
      bus(1'b1, cfg[k][19:8], v[7:0]);
      bus(1'b0, cfg[k][19:8], v[7:0]);
    end
    bus(1'b0, 12'h0FF, 8'h00);
    bus(1'b1, 12'h563, 8'hFF);
    bus(1'b0, 12'h563, 8'h00);
    v = $random(seed);
    vconv_over <= v[7:0] | 8'h01;
    @(posedge clk);
    vconv_over <= 8'h00;
    idle(1);
    bus(1'b0, 12'h563, v[7:0] | 8'h01);
    bus(1'b1, 12'h562, 8'hFF);
    bus(1'b1, 12'h562, 8'h00);
    bus(1'b0, 12'h563, 8'h00);
    $display("test registers and sticky bits done");
    for (k = 0; k < 8; k++)
      bus(1'b1, cfg[k][19:8], cfg[k][7:0]);
    idle(30);
    amp_a <= probe;
    ov <= 1'b1;
    @(posedge clk);
    amp_a <= 14'h0000;
    ov <= 1'b0;
    idle(40);
    check({13'h0, probe_ctrl}, 16'h0002, "overrange control bit");
    check({2'h0, pb[13:0]}, 16'h0000, "channel b data");
    check({13'h0, pb[16:14]}, 16'h0002, "channel b control bits");
    flip = 1'b1;
    amp_a <= 14'h1388;
    @(posedge clk);
    amp_a <= 14'h0BB8;
    idle(60);
    check({14'h0, alert_a, alert_b}, 16'h0002, "alert held in band");
    check({13'h0, out_ctrl_a}, 16'h0004, "alert control bit");
    amp_a <= 14'h0000;
    idle(50);
    check({14'h0, alert_a, alert_b}, 16'h0000, "alert cleared");
    check({13'h0, out_ctrl_a}, 16'h0000, "alert control bit cleared");
    $display("test level alert done");
    for (k = 8; k < 16; k++)
      bus(1'b1, cfg[k][19:8], cfg[k][7:0]);
    v = $random(seed);
    amp_a <= {2'b00, v[11:0]} | 14'h0800;
    amp_b <= {3'b000, v[10:0]};
    bus(1'b1, 12'h270, 8'h02);
    idle(1);
    frames(2);
    fq.push_back({2'b00, amp_a});
    frames(1);
    bus(1'b0, 12'h274, amp_a[7:0]);
    bus(1'b0, 12'h275, {3'b000, amp_a[12:8]});
    idle(1);
    amp_b <= 14'h1FFF;
    frames(2);
    fq.push_back(16'h1FFF);
    frames(1);
    $display("test peak monitor done");
    saw_full = 1'b0;
    slow <= 1'b1;
    idle(40);
    check({15'h0, saw_full}, 16'h0001, "buffer full under stall");
    slow <= 1'b0;
    idle(10);
    $display("test stall done");
    results();
  end
endmodule // lvmon_top_bench
